// ### wrt_timer.sv
// Wake-up rollover timer with APB register access
`timescale 1ns/1ns
module wrt_timer #(
    parameter int unsigned OVF_DELAY = wrt_pkg::WRT_OVF_DELAY_STAGES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wake_ext_clock,
    output logic wake_irq_request,
    output logic wake_single_step_ctrl,
    output logic irq
);

    typedef struct packed {
        logic [7:0] count;
        logic flag;
        logic irq_enable;
        logic run_enable;
        logic oversample;
        logic single_step;
        logic [1:0] status;
        logic [1:0] mask;
        logic clk_prev;
        logic gate_prev;
        logic [31:0] rdata;
        logic slverr;
    } wrt_state_s;

    wrt_state_s st_ff;
    wrt_state_s nxt_st;

    logic ext_clk_sync;
    logic ovf_now;
    logic ovf_delayed;
    logic ovf_direct;
    logic setup;
    logic wr_access;
    logic rd_setup;
    logic mapped;
    logic tick;
    logic gate;
    logic [31:0] rd_mux;

    // ------------------------------------------------------------------
    // External clock capture
    // ------------------------------------------------------------------
    // The pin is asynchronous; two flops before any edge detection
    wrt_sync #(
        .STAGES(wrt_pkg::WRT_PIN_SYNC_STAGES)
    ) u_clk_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(wake_ext_clock),
        .q(ext_clk_sync)
    );

    // Rollover path used when the clock is not oversampled
    wrt_sync #(
        .STAGES(OVF_DELAY)
    ) u_ovf_delay (
        .pclk(pclk),
        .presetn(presetn),
        .d(ovf_direct),
        .q(ovf_delayed)
    );

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    assign setup = psel & ~penable;
    assign rd_setup = setup & ~pwrite;
    assign wr_access = psel & penable & pwrite & ~st_ff.slverr;
    assign pready = psel & penable;
    assign prdata = st_ff.rdata;
    assign pslverr = st_ff.slverr & psel & penable;

    always_comb begin
        unique case (paddr)
            wrt_pkg::WRT_OFS_COUNT,
            wrt_pkg::WRT_OFS_CONFIG,
            wrt_pkg::WRT_OFS_EXTCFG,
            wrt_pkg::WRT_OFS_STATUS,
            wrt_pkg::WRT_OFS_MASK: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Count edge: a rising edge of the synchronised external clock
    assign tick = ext_clk_sync & ~st_ff.clk_prev;
    assign ovf_now = tick & (st_ff.count == wrt_pkg::WRT_COUNT_MAX);
    // Direct mode reports rollovers late through the delay line
    assign ovf_direct = ovf_now & ~st_ff.oversample;
    assign gate = st_ff.irq_enable & st_ff.run_enable;

    always_comb begin
        rd_mux = '0;
        unique case (paddr)
            wrt_pkg::WRT_OFS_COUNT: begin
                rd_mux[wrt_pkg::WRT_COUNT_W-1:0] = st_ff.count;
            end
            wrt_pkg::WRT_OFS_CONFIG: begin
                rd_mux[wrt_pkg::WRT_CFG_FLAG_BIT] = st_ff.flag;
                rd_mux[wrt_pkg::WRT_CFG_IE_BIT] = st_ff.irq_enable;
                rd_mux[wrt_pkg::WRT_CFG_EN_BIT] = st_ff.run_enable;
            end
            wrt_pkg::WRT_OFS_EXTCFG: begin
                rd_mux[wrt_pkg::WRT_EXTCFG_SSTEP_BIT] = st_ff.single_step;
                rd_mux[wrt_pkg::WRT_EXTCFG_OVS_BIT] = st_ff.oversample;
            end
            wrt_pkg::WRT_OFS_STATUS: begin
                rd_mux[wrt_pkg::WRT_IRQ_W-1:0] = st_ff.status;
            end
            wrt_pkg::WRT_OFS_MASK: begin
                rd_mux[wrt_pkg::WRT_IRQ_W-1:0] = st_ff.mask;
            end
            default: rd_mux = '0;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic ovf_set;
        logic repend;
        ovf_set = 1'b0;
        repend = 1'b0;
        nxt_st = st_ff;
        nxt_st.clk_prev = ext_clk_sync;
        nxt_st.gate_prev = gate;

        // Read data captured in setup so it holds through the access
        if (setup) begin
            nxt_st.slverr = ~mapped;
            nxt_st.rdata = rd_setup ? rd_mux : '0;
        end

        // Counter free-runs; software write wins over a tick
        if (tick) begin
            nxt_st.count = st_ff.count + 8'h01;
        end
        if (wr_access && paddr == wrt_pkg::WRT_OFS_COUNT && pstrb[0]) begin
            nxt_st.count = pwdata[wrt_pkg::WRT_COUNT_W-1:0];
        end

        if (wr_access && paddr == wrt_pkg::WRT_OFS_CONFIG && pstrb[0]) begin
            nxt_st.irq_enable = pwdata[wrt_pkg::WRT_CFG_IE_BIT];
            nxt_st.run_enable = pwdata[wrt_pkg::WRT_CFG_EN_BIT];
            // Writing one clears the flag
            if (pwdata[wrt_pkg::WRT_CFG_FLAG_BIT]) begin
                nxt_st.flag = 1'b0;
            end
        end
        if (wr_access && paddr == wrt_pkg::WRT_OFS_EXTCFG && pstrb[0]) begin
            nxt_st.single_step = pwdata[wrt_pkg::WRT_EXTCFG_SSTEP_BIT];
            nxt_st.oversample = pwdata[wrt_pkg::WRT_EXTCFG_OVS_BIT];
        end

        // Oversampled rollover is seen at once, direct one three cycles on
        ovf_set = st_ff.oversample ? ovf_now : ovf_delayed;
        // Set after clear so a rollover in the clear cycle is kept
        if (ovf_set) begin
            nxt_st.flag = 1'b1;
        end

        // Gate dropping with the flag still up counts as a fresh event
        repend = st_ff.gate_prev & ~gate & st_ff.flag;

        if (wr_access && paddr == wrt_pkg::WRT_OFS_STATUS && pstrb[0]) begin
            nxt_st.status = st_ff.status & ~pwdata[wrt_pkg::WRT_IRQ_W-1:0];
        end
        if (wr_access && paddr == wrt_pkg::WRT_OFS_MASK && pstrb[0]) begin
            nxt_st.mask = pwdata[wrt_pkg::WRT_IRQ_W-1:0];
        end
        if (ovf_set) begin
            nxt_st.status[wrt_pkg::WRT_ST_OVF_BIT] = 1'b1;
        end
        if (repend) begin
            nxt_st.status[wrt_pkg::WRT_ST_REPEND_BIT] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Level request also serves as the oscillator-off wake source
    assign wake_irq_request = st_ff.flag & gate;
    assign wake_single_step_ctrl = st_ff.single_step;
    assign irq = |(st_ff.status & st_ff.mask);

endmodule : wrt_timer

// ### wrt_pkg.sv
// Constants shared by the wake-up rollover timer
package wrt_pkg;

    localparam int unsigned WRT_DATA_W = 32;
    localparam int unsigned WRT_ADDR_W = 8;
    localparam int unsigned WRT_COUNT_W = 8;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] WRT_OFS_COUNT = 8'h00;
    localparam logic [7:0] WRT_OFS_CONFIG = 8'h04;
    localparam logic [7:0] WRT_OFS_EXTCFG = 8'h08;
    localparam logic [7:0] WRT_OFS_STATUS = 8'h0c;
    localparam logic [7:0] WRT_OFS_MASK = 8'h10;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned WRT_CFG_FLAG_BIT = 0;
    localparam int unsigned WRT_CFG_IE_BIT = 1;
    localparam int unsigned WRT_CFG_EN_BIT = 2;
    localparam int unsigned WRT_EXTCFG_SSTEP_BIT = 4;
    localparam int unsigned WRT_EXTCFG_OVS_BIT = 5;
    localparam int unsigned WRT_ST_OVF_BIT = 0;
    localparam int unsigned WRT_ST_REPEND_BIT = 1;
    localparam int unsigned WRT_IRQ_W = 2;

    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [7:0] WRT_COUNT_RST = 8'h00;
    localparam logic [7:0] WRT_COUNT_MAX = 8'hff;
    localparam logic [1:0] WRT_IRQ_RST = 2'h0;
    localparam int unsigned WRT_PIN_SYNC_STAGES = 2;
    localparam int unsigned WRT_OVF_DELAY_STAGES = 3;

endpackage : wrt_pkg

// ### wrt_sync.sv
// Shift-register synchroniser / fixed delay line, one bit wide
`timescale 1ns/1ns
module wrt_sync #(
    parameter int unsigned STAGES = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic d,
    output logic q
);

    typedef struct packed {
        logic [STAGES-1:0] chain;
    } wrt_sync_s;

    wrt_sync_s st_ff;
    wrt_sync_s nxt_st;

    // Only the next stage reads each stage, so the first one may settle
    always_comb begin
        nxt_st = st_ff;
        nxt_st.chain = {st_ff.chain[STAGES-2:0], d};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.chain[STAGES-1];

endmodule : wrt_sync

// ### wrt_ext_src.sv
// External wake clock source model for the wake-up timer bench
`timescale 1ns/1ns
module wrt_ext_src #(
    parameter int HALF = 40
) (
    input wire logic go,
    input wire logic [8:0] npulse,
    output logic wake_ext_clock
);
    // Stands still low between bursts, offset from pclk edges
    initial wake_ext_clock = 1'b0;
    always @(posedge go) begin
        #3;
        repeat (npulse) begin
            #HALF wake_ext_clock = 1'b1;
            #HALF wake_ext_clock = 1'b0;
        end
    end
endmodule : wrt_ext_src

// ### wrt_timer_assertions.sv
// Port-level assertions for the wake-up rollover timer
`timescale 1ns/1ns
module wrt_timer_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic wake_ext_clock,
    input wire logic wake_irq_request,
    input wire logic irq
);
    logic [11:0] ext_h_ff;
    logic acc;
    logic wr;
    logic ext_seen;
    // History long enough to cover sync plus overflow delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ext_h_ff <= 12'h000;
        else ext_h_ff <= {ext_h_ff[10:0], wake_ext_clock};
    end
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign ext_seen = |(ext_h_ff[10:0] & ~ext_h_ff[11:1]);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_ready_zero_ws: assert property (pready == acc)
        else $error("pready mismatch");
    chk_slverr_decode: assert property (acc |->
        pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h10))
        else $error("bad pslverr");
    chk_write_rdata: assert property (wr |-> prdata == 32'h0)
        else $error("prdata not zero on write");
    chk_count_upper: assert property (acc && !pwrite && paddr == 8'h00 |->
        prdata[31:8] == 24'h0) else $error("count upper bits set");
    chk_req_rise: assert property ($rose(wake_irq_request) |->
        $past(wr) || ext_seen) else $error("request rose without cause");
    chk_req_fall: assert property ($fell(wake_irq_request) |->
        $past(wr)) else $error("request fell without write");
    // A re-pend status bit lands one cycle after the disabling write
    chk_irq_rise: assert property ($rose(irq) |->
        $past(wr) || $past(wr, 2) || ext_seen)
        else $error("irq rose without cause");
    chk_irq_fall: assert property ($fell(irq) |-> $past(wr))
        else $error("irq fell without write");
    cover property ($rose(wake_irq_request));
    cover property (acc && pslverr);
    cover property ($fell(irq));
endmodule : wrt_timer_chk
bind wrt_timer wrt_timer_chk u_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .wake_ext_clock,
    .wake_irq_request, .irq);

// ### wrt_timer_tb_top.sv
// Self-checking bench for the wake-up rollover timer
`timescale 1ns/1ns
module wrt_timer_tb_top;
    logic pclk, presetn, psel, penable, pwrite, go, ext, req, ss, irq;
    logic pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [8:0] npulse;
    int num_errors, n_tests;
    wrt_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wake_ext_clock(ext), .wake_irq_request(req),
        .wake_single_step_ctrl(ss), .irq(irq));
    wrt_ext_src src (.go(go), .npulse(npulse), .wake_ext_clock(ext));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] e);
        n_tests++;
        if (got !== e) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdc
    // Stray far-side clock edges would break the exact counts below
    task automatic pulses(input logic [8:0] n);
        npulse <= n;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        repeat (n * 10 + 20) @(posedge pclk);
    endtask : pulses
    task automatic stop_test;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    task automatic t_reset;
        for (int i = 0; i < 5; i++) rdc(8'(4 * i), 32'h0);
        chk({30'h0, req, irq}, 32'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_count;
        apb(1'b1, 8'h00, 32'h5a);
        pstrb <= 4'he;
        apb(1'b1, 8'h00, 32'h3c);
        pstrb <= 4'hf;
        rdc(8'h00, 32'h5a);
        apb(1'b1, 8'h14, 32'h1);
        chk(32'(err), 32'h1);
        apb(1'b1, 8'h08, 32'h10);
        chk(32'(ss), 32'h1);
        $display("test count done");
    endtask : t_count
    task automatic t_roll;
        // Idle cycle after the mode write stands in for the settling gap
        apb(1'b1, 8'h08, 32'h20);
        apb(1'b1, 8'h00, 32'hfe);
        pulses(9'd258);
        rdc(8'h00, 32'h0);
        rdc(8'h04, 32'h1);
        $display("test rollover done");
    endtask : t_roll
    task automatic t_irq;
        apb(1'b1, 8'h04, 32'h2);
        chk(32'(req), 32'h0);
        apb(1'b1, 8'h04, 32'h6);
        chk(32'(req), 32'h1);
        apb(1'b1, 8'h04, 32'h4);
        chk(32'(req), 32'h0);
        rdc(8'h0c, 32'h3);
        apb(1'b1, 8'h04, 32'h1);
        rdc(8'h04, 32'h0);
        $display("test irq done");
    endtask : t_irq
    task automatic t_mask;
        chk(32'(irq), 32'h0);
        apb(1'b1, 8'h10, 32'h1);
        chk(32'(irq), 32'h1);
        apb(1'b1, 8'h0c, 32'h1);
        chk(32'(irq), 32'h0);
        rdc(8'h0c, 32'h2);
        $display("test mask done");
    endtask : t_mask
    task automatic meas(input logic [31:0] x, output int c);
        apb(1'b1, 8'h08, x);
        apb(1'b1, 8'h00, 32'hfe);
        apb(1'b1, 8'h04, 32'h6);
        npulse <= 9'd2;
        go <= 1'b1;
        c = 0;
        @(posedge pclk);
        go <= 1'b0;
        while (req !== 1'b1 && c < 300) begin
            @(posedge pclk);
            c++;
        end
        apb(1'b1, 8'h04, 32'h1);
        apb(1'b1, 8'h0c, 32'h3);
    endtask : meas
    task automatic t_delay;
        int c0;
        int c1;
        meas(32'h20, c1);
        meas(32'h0, c0);
        chk(32'(c0 - c1), 32'h3);
        $display("test delay done");
    endtask : t_delay
    initial begin
        {psel, penable, pwrite, go, presetn} = 5'h0;
        {paddr, pwdata, npulse} = 49'h0;
        pstrb = 4'hf;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_count;
        t_roll;
        t_irq;
        t_mask;
        t_delay;
        stop_test;
    end
    initial begin
        #200000;
        num_errors++;
        stop_test;
    end
endmodule : wrt_timer_tb_top
